// [inc/fpx_pkg.sv]
// Formats, rounding modes, flag positions and encoding helpers for the
// floating-point exception unit. Assumes operands up to 80 bits wide.
package fpx_pkg;

  typedef enum logic [1:0] {FMT_SINGLE, FMT_DOUBLE, FMT_EXT} fmt_t;

  typedef enum logic [1:0] {
    RND_NEAREST = 2'h0,
    RND_DOWN = 2'h1,
    RND_UP = 2'h2,
    RND_ZERO = 2'h3
  } round_t;

  // Flag and cause bit positions
  localparam int FLAG_INV = 0;
  localparam int FLAG_DEN = 1;
  localparam int FLAG_ZDIV = 2;
  localparam int FLAG_OVF = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // Unbiased exponent limits for overflow
  localparam logic [16:0] OVF_LIM_SINGLE = 17'h0_0080;
  localparam logic [16:0] OVF_LIM_DOUBLE = 17'h0_0400;
  localparam logic [16:0] OVF_LIM_EXT = 17'h0_4000;
  // Exponent bias and wrap adjustment for the biased result
  localparam logic [14:0] BIAS_SINGLE = 15'h007F;
  localparam logic [14:0] BIAS_DOUBLE = 15'h03FF;
  localparam logic [14:0] BIAS_EXT = 15'h3FFF;
  localparam logic [16:0] WRAP_SINGLE = 17'h0_00C0;
  localparam logic [16:0] WRAP_DOUBLE = 17'h0_0600;
  localparam logic [16:0] WRAP_EXT = 17'h0_6000;
  // All-ones exponents
  localparam logic [14:0] EMAX_SINGLE = 15'h00FF;
  localparam logic [14:0] EMAX_DOUBLE = 15'h07FF;
  localparam logic [14:0] EMAX_EXT = 15'h7FFF;
  // Quiet-NaN indefinite fraction
  localparam logic [62:0] QNAN_FRAC = 63'h4000_0000_0000_0000;

  function automatic logic [14:0] exp_max(fmt_t f);
    case (f)
      FMT_SINGLE: exp_max = EMAX_SINGLE;
      FMT_DOUBLE: exp_max = EMAX_DOUBLE;
      default: exp_max = EMAX_EXT;
    endcase
  endfunction

  function automatic logic [14:0] bias(fmt_t f);
    case (f)
      FMT_SINGLE: bias = BIAS_SINGLE;
      FMT_DOUBLE: bias = BIAS_DOUBLE;
      default: bias = BIAS_EXT;
    endcase
  endfunction

  function automatic logic [16:0] wrap(fmt_t f);
    case (f)
      FMT_SINGLE: wrap = WRAP_SINGLE;
      FMT_DOUBLE: wrap = WRAP_DOUBLE;
      default: wrap = WRAP_EXT;
    endcase
  endfunction

  function automatic logic [16:0] ovf_limit(fmt_t f);
    case (f)
      FMT_SINGLE: ovf_limit = OVF_LIM_SINGLE;
      FMT_DOUBLE: ovf_limit = OVF_LIM_DOUBLE;
      default: ovf_limit = OVF_LIM_EXT;
    endcase
  endfunction

  // Fraction is left aligned below the integer bit
  function automatic logic [79:0] pack_fp(fmt_t f, logic s, logic [14:0] e, logic [62:0] m);
    case (f)
      FMT_SINGLE: pack_fp = {48'h0000_0000_0000, s, e[7:0], m[62:40]};
      FMT_DOUBLE: pack_fp = {16'h0000, s, e[10:0], m[62:11]};
      default: pack_fp = {s, e, e != 15'h0000, m};
    endcase
  endfunction

endpackage

// [inc/fpx_class_if.sv]
// Operand classification carried from the classifier to the exception unit.
// Assumes one instance per operand.
`timescale 1ns/1ps
interface fpx_class_if;
  logic sign;
  logic zero;
  logic denorm;
  logic inf;
  logic nan;
  logic snan;
  modport src(output sign, zero, denorm, inf, nan, snan);
  modport dst(input sign, zero, denorm, inf, nan, snan);
endinterface

// [rtl/fp_operand_classify.sv]
// Classifies one operand of the selected format.
// Assumes a purely combinational path from operand to class bits.
`timescale 1ns/1ps
module fp_operand_classify (
  // Operand
  input wire logic [79:0] value,
  input wire fpx_pkg::fmt_t fmt,
  // Class
  fpx_class_if.src cls
);
  logic [14:0] e;
  logic [62:0] m;
  logic s;

  always_comb begin
    case (fmt)
      fpx_pkg::FMT_SINGLE: begin
        s = value[31];
        e = {7'h00, value[30:23]};
        m = {value[22:0], 40'h00_0000_0000};
      end
      fpx_pkg::FMT_DOUBLE: begin
        s = value[63];
        e = {4'h0, value[62:52]};
        m = {value[51:0], 11'h000};
      end
      default: begin
        s = value[79];
        e = value[78:64];
        m = value[62:0];
      end
    endcase
  end

  // Denormal and special encodings
  assign cls.sign = s;
  assign cls.zero = e == 15'h0000 && m == '0;
  assign cls.denorm = e == 15'h0000 && m != '0;
  assign cls.inf = e == fpx_pkg::exp_max(fmt) && m == '0;
  assign cls.nan = e == fpx_pkg::exp_max(fmt) && m != '0;
  assign cls.snan = e == fpx_pkg::exp_max(fmt) && m != '0 && !m[62];
endmodule

// [rtl/fp_overflow_resp.sv]
// Masked overflow result by rounding mode and sign of the true result.
// Assumes the caller registers the value.
`timescale 1ns/1ps
module fp_overflow_resp (
  // Selection
  input wire fpx_pkg::fmt_t fmt,
  input wire logic [1:0] round_sel,
  input wire logic sign,
  // Result
  output logic [79:0] value
);
  logic use_inf;

  always_comb begin
    unique case (round_sel)
      fpx_pkg::RND_NEAREST: use_inf = 1'b1;
      fpx_pkg::RND_DOWN: use_inf = sign;
      fpx_pkg::RND_UP: use_inf = !sign;
      fpx_pkg::RND_ZERO: use_inf = 1'b0;
    endcase
    if (use_inf) begin
      value = fpx_pkg::pack_fp(fmt, sign, fpx_pkg::exp_max(fmt), '0);
    end else begin
      value = fpx_pkg::pack_fp(fmt, sign, fpx_pkg::exp_max(fmt) - 15'h0001, '1);
    end
  end
endmodule

// [rtl/fp_exception_detect_respond.sv]
// Floating-point exception detection and response: invalid, denormal,
// divide-by-zero and overflow, with sticky flags and per-class masks.
// Assumes the datapath presents operands before and results after compute.
//
// Operation
// - Masked invalid sets invalid flag, writes quiet NaN indefinite to destination.
// - Unmasked invalid sets flag, calls handler, operands untouched.
// - Detect any denormal operand of an arithmetic instruction; the code does not flag it when invalid or divide-by-zero is detected.
// - Masked denormal sets flag and executes on the denormal value.
// - Unmasked denormal sets flag, calls handler, operands untouched.
// - Divide-by-zero only for finite non-zero dividend over zero divisor.
// - Masked divide-by-zero sets flag, returns infinity with XOR of signs.
// - Unmasked divide-by-zero sets flag, calls handler, operands untouched.
// - Overflow when rounded magnitude reaches 2^128, 2^1024 or 2^16384.
// - Masked overflow sets flag, result from rounding mode and sign.
// - Nearest gives infinity; directed modes give infinity or largest finite.
// - Unmasked overflow calls handler; SIMD keeps destination, stack unit stores biased.
// - Each class has a mask: set means default result, clear means handler.
// - Flags are sticky, accumulating until software clears them.
// - Rounding select 00 nearest, 01 down, 10 up, 11 toward zero.
// - Invalid, zero-divide, denormal are caught before the arithmetic runs.
`timescale 1ns/1ps
module fp_exception_detect_respond (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Operation request
  input wire logic op_valid,
  output logic op_ready,
  input wire logic op_div,
  input wire fpx_pkg::fmt_t op_fmt,
  input wire logic [79:0] op_a,
  input wire logic [79:0] op_b,
  input wire logic op_invalid,
  // Operands forwarded to the arithmetic
  output logic exec_go,
  output logic exec_div,
  output fpx_pkg::fmt_t exec_fmt,
  output logic [79:0] exec_a,
  output logic [79:0] exec_b,
  // Rounded result from the arithmetic
  input wire logic res_valid,
  input wire logic res_simd,
  input wire fpx_pkg::fmt_t res_fmt,
  input wire logic res_sign,
  input wire logic [16:0] res_exp,
  input wire logic [62:0] res_frac,
  // Destination write
  output logic dest_wr,
  output logic [79:0] dest_data,
  // Software handler request
  output logic handler_req,
  output logic [3:0] handler_cause,
  // Control and status
  input wire logic invalid_mask,
  input wire logic subnormal_mask,
  input wire logic zero_divide_mask,
  input wire logic overflow_mask,
  input wire logic [1:0] round_select,
  input wire logic flag_wr,
  input wire logic [3:0] flag_wdata,
  output logic invalid_flag,
  output logic subnormal_operand_flag,
  output logic zero_divide_flag,
  output logic overflow_flag
);

  typedef struct packed {
    logic [3:0] flags;
    logic exec_go;
    logic exec_div;
    fpx_pkg::fmt_t exec_fmt;
    logic [79:0] exec_a;
    logic [79:0] exec_b;
    logic dest_wr;
    logic [79:0] dest_data;
    logic handler_req;
    logic [3:0] cause;
  } state_t;

  state_t st_reg;
  state_t st_next;

  fpx_class_if cls_a ();
  fpx_class_if cls_b ();

  logic take;
  logic inv_det;
  logic zd_det;
  logic den_det;
  logic ovf_det;
  logic pre_trap;
  logic [3:0] set_bits;
  logic [3:0] mask_bits;
  logic [79:0] ovf_value;
  logic [16:0] wrap_exp;
  logic [16:0] norm_exp;

  // Operand classification
  fp_operand_classify u_cls_a (
    .value(op_a),
    .fmt(op_fmt),
    .cls(cls_a)
  );

  fp_operand_classify u_cls_b (
    .value(op_b),
    .fmt(op_fmt),
    .cls(cls_b)
  );

  // Masked overflow value
  fp_overflow_resp u_ovf (
    .fmt(res_fmt),
    .round_sel(round_select),
    .sign(res_sign),
    .value(ovf_value)
  );

  // Results have the destination port, so new operations wait
  assign op_ready = !res_valid;
  assign take = op_valid && op_ready;

  // Pre-computation detection
  always_comb begin
    inv_det = take && (cls_a.snan || cls_b.snan || op_invalid ||
      (op_div && ((cls_a.zero && cls_b.zero) || (cls_a.inf && cls_b.inf))));
    zd_det = take && !inv_det && op_div && cls_b.zero &&
      !cls_a.zero && !cls_a.inf && !cls_a.nan;
    den_det = take && !inv_det && !zd_det && (cls_a.denorm || cls_b.denorm);
  end

  // Post-computation detection
  assign ovf_det = res_valid && $signed(res_exp) >= $signed(fpx_pkg::ovf_limit(res_fmt));

  always_comb begin
    set_bits = 4'h0;
    set_bits[fpx_pkg::FLAG_INV] = inv_det;
    set_bits[fpx_pkg::FLAG_DEN] = den_det;
    set_bits[fpx_pkg::FLAG_ZDIV] = zd_det;
    set_bits[fpx_pkg::FLAG_OVF] = ovf_det;
    mask_bits = 4'h0;
    mask_bits[fpx_pkg::FLAG_INV] = invalid_mask;
    mask_bits[fpx_pkg::FLAG_DEN] = subnormal_mask;
    mask_bits[fpx_pkg::FLAG_ZDIV] = zero_divide_mask;
    mask_bits[fpx_pkg::FLAG_OVF] = overflow_mask;
  end

  assign pre_trap = ((set_bits & ~mask_bits) & 4'h7) != 4'h0;

  // Exponents of the delivered result
  assign wrap_exp = res_exp - fpx_pkg::wrap(res_fmt) + {2'b00, fpx_pkg::bias(res_fmt)};
  assign norm_exp = res_exp + {2'b00, fpx_pkg::bias(res_fmt)};

  always_comb begin
    st_next = st_reg;
    st_next.exec_go = 1'b0;
    st_next.dest_wr = 1'b0;
    st_next.handler_req = 1'b0;
    st_next.cause = 4'h0;
    // A detection in the same cycle as a software write still lands
    if (flag_wr) begin
      st_next.flags = flag_wdata;
    end
    st_next.flags = st_next.flags | set_bits;
    if (take) begin
      if (pre_trap) begin
        st_next.handler_req = 1'b1;
        st_next.cause = set_bits & ~mask_bits;
      end else if (inv_det) begin
        st_next.dest_wr = 1'b1;
        st_next.dest_data = fpx_pkg::pack_fp(op_fmt, 1'b1, fpx_pkg::exp_max(op_fmt), fpx_pkg::QNAN_FRAC);
      end else if (zd_det) begin
        st_next.dest_wr = 1'b1;
        st_next.dest_data = fpx_pkg::pack_fp(op_fmt, cls_a.sign ^ cls_b.sign,
          fpx_pkg::exp_max(op_fmt), '0);
      end else begin
        st_next.exec_go = 1'b1;
        st_next.exec_div = op_div;
        st_next.exec_fmt = op_fmt;
        st_next.exec_a = op_a;
        st_next.exec_b = op_b;
      end
    end
    if (res_valid) begin
      if (ovf_det && !overflow_mask) begin
        st_next.handler_req = 1'b1;
        st_next.cause = set_bits & ~mask_bits;
        if (!res_simd) begin
          st_next.dest_wr = 1'b1;
          st_next.dest_data = fpx_pkg::pack_fp(res_fmt, res_sign, wrap_exp[14:0], res_frac);
        end
      end else if (ovf_det) begin
        st_next.dest_wr = 1'b1;
        st_next.dest_data = ovf_value;
      end else begin
        st_next.dest_wr = 1'b1;
        st_next.dest_data = fpx_pkg::pack_fp(res_fmt, res_sign, norm_exp[14:0], res_frac);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.flags <= fpx_pkg::FLAGS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign exec_go = st_reg.exec_go;
  assign exec_div = st_reg.exec_div;
  assign exec_fmt = st_reg.exec_fmt;
  assign exec_a = st_reg.exec_a;
  assign exec_b = st_reg.exec_b;
  assign dest_wr = st_reg.dest_wr;
  assign dest_data = st_reg.dest_data;
  assign handler_req = st_reg.handler_req;
  assign handler_cause = st_reg.cause;
  assign invalid_flag = st_reg.flags[fpx_pkg::FLAG_INV];
  assign subnormal_operand_flag = st_reg.flags[fpx_pkg::FLAG_DEN];
  assign zero_divide_flag = st_reg.flags[fpx_pkg::FLAG_ZDIV];
  assign overflow_flag = st_reg.flags[fpx_pkg::FLAG_OVF];

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  inv_masked_a: assert property (
    inv_det && invalid_mask |=> dest_wr && invalid_flag && !exec_go &&
      dest_data == fpx_pkg::pack_fp($past(op_fmt), 1'b1,
        fpx_pkg::exp_max($past(op_fmt)), fpx_pkg::QNAN_FRAC))
    else $error("masked invalid did not write the indefinite");

  inv_unmasked_a: assert property (
    inv_det && !invalid_mask |=> handler_req && invalid_flag && !dest_wr && !exec_go ##1 !handler_req)
    else $error("unmasked invalid did not trap cleanly");

  den_detect_a: assert property (
    take && (cls_a.denorm || cls_b.denorm) && !inv_det && !zd_det |=> subnormal_operand_flag)
    else $error("denormal operand not flagged");

  den_masked_a: assert property (
    den_det && subnormal_mask |=> exec_go && exec_a == $past(op_a) && exec_b == $past(op_b) && !handler_req)
    else $error("masked denormal did not proceed");

  den_unmasked_a: assert property (
    den_det && !subnormal_mask |=> handler_req && handler_cause[fpx_pkg::FLAG_DEN] && !exec_go && !dest_wr)
    else $error("unmasked denormal did not trap");

  zd_only_div_a: assert property (
    take && !op_div && !flag_wr && !zero_divide_flag |=> !zero_divide_flag)
    else $error("zero divide flagged without a divide");

  zd_masked_a: assert property (
    zd_det && zero_divide_mask |=> dest_wr && zero_divide_flag &&
      dest_data == fpx_pkg::pack_fp($past(op_fmt), $past(cls_a.sign) ^ $past(cls_b.sign),
        fpx_pkg::exp_max($past(op_fmt)), '0))
    else $error("masked zero divide result wrong");

  zd_unmasked_a: assert property (
    zd_det && !zero_divide_mask |=> handler_req && !dest_wr && !exec_go)
    else $error("unmasked zero divide did not trap");

  ovf_detect_a: assert property (
    res_valid && !flag_wr && !overflow_flag &&
      $signed(res_exp) < $signed(fpx_pkg::ovf_limit(res_fmt)) |=> !overflow_flag)
    else $error("overflow flagged below threshold");

  ovf_nearest_a: assert property (
    ovf_det && overflow_mask && round_select == fpx_pkg::RND_NEAREST |=>
      overflow_flag && dest_wr && !handler_req &&
      dest_data == fpx_pkg::pack_fp($past(res_fmt), $past(res_sign), fpx_pkg::exp_max($past(res_fmt)), '0))
    else $error("masked overflow at nearest not infinity");

  ovf_zero_a: assert property (
    ovf_det && overflow_mask && round_select == fpx_pkg::RND_ZERO |=>
      dest_data == fpx_pkg::pack_fp($past(res_fmt), $past(res_sign),
        fpx_pkg::exp_max($past(res_fmt)) - 15'h0001, '1))
    else $error("masked overflow toward zero not largest finite");

  ovf_down_a: assert property (
    ovf_det && overflow_mask && round_select == fpx_pkg::RND_DOWN |=> dest_wr &&
      dest_data == fpx_pkg::pack_fp($past(res_fmt), $past(res_sign),
        fpx_pkg::exp_max($past(res_fmt)) - {14'h0000, !$past(res_sign)}, {63{!$past(res_sign)}}))
    else $error("masked overflow toward minus infinity wrong");

  ovf_up_a: assert property (
    ovf_det && overflow_mask && round_select == fpx_pkg::RND_UP |=> dest_wr &&
      dest_data == fpx_pkg::pack_fp($past(res_fmt), $past(res_sign),
        fpx_pkg::exp_max($past(res_fmt)) - {14'h0000, $past(res_sign)}, {63{$past(res_sign)}}))
    else $error("masked overflow toward plus infinity wrong");

  ovf_stack_a: assert property (
    ovf_det && !overflow_mask && !res_simd |=> handler_req && dest_wr && handler_cause[fpx_pkg::FLAG_OVF])
    else $error("unmasked stack overflow did not store and trap");

  pre_trap_a: assert property (
    take && pre_trap |=> handler_req && !exec_go && !dest_wr)
    else $error("unmasked pre-computation exception reached the arithmetic");

  ovf_simd_a: assert property (
    ovf_det && !overflow_mask && res_simd |=> handler_req && !dest_wr)
    else $error("unmasked SIMD overflow wrote destination");

  flags_sticky_a: assert property (
    !flag_wr |=> ({overflow_flag, zero_divide_flag, subnormal_operand_flag, invalid_flag} &
      $past(st_reg.flags)) == $past(st_reg.flags))
    else $error("sticky flag dropped");

  flags_write_a: assert property (
    flag_wr && !take && !res_valid |=> st_reg.flags == $past(flag_wdata))
    else $error("software flag write not applied");

  cov_inv_trap: cover property (inv_det && !invalid_mask ##1 handler_req);
  cov_den_go: cover property (den_det && subnormal_mask ##1 exec_go);
  cov_zd_inf: cover property (zd_det && zero_divide_mask ##1 dest_wr);
  cov_ovf_down: cover property (ovf_det && overflow_mask && round_select == fpx_pkg::RND_DOWN);

endmodule

// [verification/testbench.sv]
// Self-checking bench for the floating-point exception unit.
// Assumes the unit's own assertions run alongside; drives every port directly.
`timescale 1ns/1ps
module testbench;
  localparam logic [2:0] K_EXE = 3'h4;
  localparam logic [2:0] K_DST = 3'h2;
  localparam logic [2:0] K_HND = 3'h1;
  localparam logic [2:0] K_BOTH = 3'h3;
  localparam logic [79:0] ONE_S = 80'h0000_0000_0000_3F80_0000;
  localparam logic [79:0] QNAN_S = 80'h0000_0000_0000_FFC0_0000;

  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  logic op_div = 1'b0;
  fpx_pkg::fmt_t op_fmt = fpx_pkg::FMT_SINGLE;
  logic [79:0] op_a = 80'h0000_0000_0000_0000_0000;
  logic [79:0] op_b = 80'h0000_0000_0000_0000_0000;
  logic op_invalid = 1'b0;
  logic res_valid = 1'b0;
  logic res_simd = 1'b0;
  fpx_pkg::fmt_t res_fmt = fpx_pkg::FMT_SINGLE;
  logic res_sign = 1'b0;
  logic [16:0] res_exp = 17'h0_0000;
  logic [62:0] res_frac = 63'h0000_0000_0000_0000;
  logic [3:0] msk = 4'hF;
  logic [1:0] round_select = 2'h0;
  logic flag_wr = 1'b0;
  logic [3:0] flag_wdata = 4'h0;
  logic op_ready;
  logic exec_go;
  logic exec_div;
  fpx_pkg::fmt_t exec_fmt;
  logic [79:0] exec_a;
  logic [79:0] exec_b;
  logic dest_wr;
  logic [79:0] dest_data;
  logic handler_req;
  logic [3:0] handler_cause;
  logic invalid_flag;
  logic subnormal_operand_flag;
  logic zero_divide_flag;
  logic overflow_flag;
  logic [3:0] flags;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [79:0] want;

  assign flags = {overflow_flag, zero_divide_flag, subnormal_operand_flag, invalid_flag};

  always #20 ref_clk = ~ref_clk;

  fp_exception_detect_respond u_fp_exception_detect_respond (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .op_valid(op_valid), .op_ready(op_ready), .op_div(op_div), .op_fmt(op_fmt),
    .op_a(op_a), .op_b(op_b), .op_invalid(op_invalid),
    .exec_go(exec_go), .exec_div(exec_div), .exec_fmt(exec_fmt), .exec_a(exec_a), .exec_b(exec_b),
    .res_valid(res_valid), .res_simd(res_simd), .res_fmt(res_fmt), .res_sign(res_sign),
    .res_exp(res_exp), .res_frac(res_frac),
    .dest_wr(dest_wr), .dest_data(dest_data), .handler_req(handler_req), .handler_cause(handler_cause),
    .invalid_mask(msk[0]), .subnormal_mask(msk[1]), .zero_divide_mask(msk[2]), .overflow_mask(msk[3]),
    .round_select(round_select), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
    .invalid_flag(invalid_flag), .subnormal_operand_flag(subnormal_operand_flag),
    .zero_divide_flag(zero_divide_flag), .overflow_flag(overflow_flag)
  );

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Run limit
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One operation, answer visible after the taking edge
  task automatic op(input logic d, input fpx_pkg::fmt_t f, input logic [79:0] a, input logic [79:0] b,
                    input logic inv);
    @(posedge ref_clk);
    #1;
    op_valid = 1'b1;
    op_div = d;
    op_fmt = f;
    op_a = a;
    op_b = b;
    op_invalid = inv;
    @(posedge ref_clk);
    #1;
    op_valid = 1'b0;
  endtask

  // One rounded result; operations are refused meanwhile
  task automatic res(input logic simd, input fpx_pkg::fmt_t f, input logic s, input logic [16:0] e,
                     input logic [62:0] fr);
    @(posedge ref_clk);
    #1;
    res_valid = 1'b1;
    res_simd = simd;
    res_fmt = f;
    res_sign = s;
    res_exp = e;
    res_frac = fr;
    #1;
    chk(op_ready, 1'b0);
    @(posedge ref_clk);
    #1;
    res_valid = 1'b0;
  endtask

  task automatic flagw(input logic [3:0] v);
    @(posedge ref_clk);
    #1;
    flag_wr = 1'b1;
    flag_wdata = v;
    @(posedge ref_clk);
    #1;
    flag_wr = 1'b0;
  endtask

  task automatic expect_out(input logic [2:0] k, input logic [3:0] c, input logic [79:0] dd);
    chk({exec_go, dest_wr, handler_req}, k);
    chk(handler_cause, c);
    if (k[1]) begin
      chk(dest_data, dd);
    end
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    chk(flags, 4'h0);
    // Masked pre-computation cases
    op(1'b0, fpx_pkg::FMT_SINGLE, 80'h0000_0000_0000_7F80_0001, ONE_S, 1'b0);
    expect_out(K_DST, 4'h0, QNAN_S);
    chk(flags, 4'h1);
    op(1'b0, fpx_pkg::FMT_EXT, 80'h3FFF_8000_0000_0000_0000, 80'h3FFF_8000_0000_0000_0000, 1'b1);
    expect_out(K_DST, 4'h0, 80'hFFFF_C000_0000_0000_0000);
    op(1'b0, fpx_pkg::FMT_SINGLE, 80'h0000_0000_0000_0000_0001, ONE_S, 1'b0);
    expect_out(K_EXE, 4'h0, 80'h0);
    chk(exec_a, 80'h0000_0000_0000_0000_0001);
    chk(exec_b, ONE_S);
    chk(flags, 4'h3);
    op(1'b0, fpx_pkg::FMT_DOUBLE, 80'h0000_3FF0_0000_0000_0000, 80'h0000_0000_0000_0000_0001, 1'b0);
    expect_out(K_EXE, 4'h0, 80'h0);
    chk(exec_fmt, fpx_pkg::FMT_DOUBLE);
    chk(exec_b, 80'h0000_0000_0000_0000_0001);
    chk(exec_div, 1'b0);
    chk(flags, 4'h3);
    op(1'b1, fpx_pkg::FMT_SINGLE, 80'h0000_0000_0000_C000_0000, 80'h0, 1'b0);
    expect_out(K_DST, 4'h0, 80'h0000_0000_0000_FF80_0000);
    chk(flags, 4'h7);
    flagw(4'h0);
    chk(flags, 4'h0);
    op(1'b1, fpx_pkg::FMT_SINGLE, 80'h0, 80'h0, 1'b0);
    expect_out(K_DST, 4'h0, QNAN_S);
    chk(flags, 4'h1);
    flagw(4'h0);
    op(1'b1, fpx_pkg::FMT_SINGLE, 80'h0000_0000_0000_7F80_0000, 80'h0, 1'b0);
    expect_out(K_EXE, 4'h0, 80'h0);
    op(1'b1, fpx_pkg::FMT_SINGLE, ONE_S, 80'h0000_0000_0000_4000_0000, 1'b0);
    expect_out(K_EXE, 4'h0, 80'h0);
    chk(exec_div, 1'b1);
    chk(exec_b, 80'h0000_0000_0000_4000_0000);
    chk(flags, 4'h0);
    // Unmasked pre-computation cases
    msk = 4'h0;
    op(1'b0, fpx_pkg::FMT_SINGLE, ONE_S, ONE_S, 1'b1);
    expect_out(K_HND, 4'h1, 80'h0);
    op(1'b0, fpx_pkg::FMT_SINGLE, ONE_S, 80'h0000_0000_0000_0000_0001, 1'b0);
    expect_out(K_HND, 4'h2, 80'h0);
    op(1'b1, fpx_pkg::FMT_SINGLE, ONE_S, 80'h0000_0000_0000_8000_0000, 1'b0);
    expect_out(K_HND, 4'h4, 80'h0);
    chk(flags, 4'h7);
    flagw(4'h8);
    chk(flags, 4'h8);
    flagw(4'h0);
    // Masked overflow in every rounding mode and sign
    msk = 4'hF;
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 4; m++) begin
        round_select = m[1:0];
        if (m == 0 || (m == 1 && s == 1) || (m == 2 && s == 0)) begin
          want = {48'h0, s[0], 8'hFF, 23'h00_0000};
        end else begin
          want = {48'h0, s[0], 8'hFE, 23'h7F_FFFF};
        end
        res(1'b1, fpx_pkg::FMT_SINGLE, s[0], 17'h0_0080, 63'h0);
        expect_out(K_DST, 4'h0, want);
      end
    end
    chk(flags, 4'h8);
    round_select = 2'h0;
    // Thresholds per format
    res(1'b1, fpx_pkg::FMT_SINGLE, 1'b0, 17'h0_007F, 63'h4000_0000_0000_0000);
    expect_out(K_DST, 4'h0, 80'h0000_0000_0000_7F40_0000);
    res(1'b1, fpx_pkg::FMT_SINGLE, 1'b0, 17'h1_FFFB, 63'h0);
    expect_out(K_DST, 4'h0, 80'h0000_0000_0000_3D00_0000);
    res(1'b1, fpx_pkg::FMT_DOUBLE, 1'b0, 17'h0_03FF, 63'h0);
    expect_out(K_DST, 4'h0, 80'h0000_7FE0_0000_0000_0000);
    res(1'b1, fpx_pkg::FMT_DOUBLE, 1'b0, 17'h0_0400, 63'h0);
    expect_out(K_DST, 4'h0, 80'h0000_7FF0_0000_0000_0000);
    res(1'b1, fpx_pkg::FMT_EXT, 1'b0, 17'h0_3FFF, 63'h0);
    expect_out(K_DST, 4'h0, 80'h7FFE_8000_0000_0000_0000);
    res(1'b1, fpx_pkg::FMT_EXT, 1'b1, 17'h0_4000, 63'h0);
    expect_out(K_DST, 4'h0, 80'hFFFF_8000_0000_0000_0000);
    // Unmasked overflow, both units
    msk = 4'h0;
    flagw(4'h0);
    res(1'b1, fpx_pkg::FMT_SINGLE, 1'b0, 17'h0_0080, 63'h0);
    expect_out(K_HND, 4'h8, 80'h0);
    res(1'b0, fpx_pkg::FMT_SINGLE, 1'b0, 17'h0_0080, 63'h0);
    expect_out(K_BOTH, 4'h8, 80'h0000_0000_0000_1F80_0000);
    chk(flags, 4'h8);
    repeat (2) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule
